// File: tpoc_defines.svh
// constants for the timing pattern output controller: offsets, resets, fields
// assumes inclusion by bare name from the package and design modules
`ifndef TPOC_DEFINES_SVH
`define TPOC_DEFINES_SVH

// ----------------------------------------
// register offsets (byte addresses on the plain port)
// ----------------------------------------
`define TPOC_OFS_NDL 4'h0
`define TPOC_OFS_NDH 4'h1
`define TPOC_OFS_LTE 4'h2
`define TPOC_OFS_UTE 4'h3
`define TPOC_OFS_TSEL 4'h4
`define TPOC_OFS_OVM 4'h5
`define TPOC_OFS_PDR_LO 4'h6
`define TPOC_OFS_PDR_HI 4'h7
`define TPOC_OFS_PCTL_LO 4'h8
`define TPOC_OFS_PCTL_HI 4'h9
`define TPOC_OFS_PCTL2_LO 4'ha
`define TPOC_OFS_PCTL2_HI 4'hb

// ----------------------------------------
// reset values
// ----------------------------------------
`define TPOC_RST_BYTE0 8'h00
`define TPOC_RST_TSEL 8'hff
`define TPOC_RST_OVM 8'hf0
`define TPOC_OVM_RSVD 4'hf
`define TPOC_RD_NONE 8'h00

// ----------------------------------------
// fields
// ----------------------------------------
`define TPOC_GRP_W 4
`define TPOC_NGRP 4
`define TPOC_NCH 4
`define TPOC_SEL_W 2
`define TPOC_RST_NIB 4'h0
`define TPOC_RST_PINS 16'h0000

`endif

// File: tpoc_pkg.sv
// types for the timing pattern output controller
// assumes tpoc_defines.svh is on the include path
`include "tpoc_defines.svh"

package tpoc_pkg;
  typedef logic [7:0] tpoc_byte_t;
  typedef logic [3:0] tpoc_addr_t;
  typedef logic [1:0] tpoc_chsel_t;
  typedef enum logic {TPOC_ORDINARY, TPOC_NONOVERLAP} tpoc_mode_e;
endpackage : tpoc_pkg

// File: tpoc_byte_reg.sv
// one byte register with reset value, written from the register port
// assumes synchronous active-high reset on clk_sys
`timescale 1ns/1ps

module tpoc_byte_reg #(
  parameter logic [7:0] RST_VAL = 8'h00
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic we,
  input wire logic [7:0] wdata,
  output logic [7:0] q
);
  // standby is not a reset: only rst reloads the value
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= RST_VAL;
    end else if (we) begin
      q <= wdata;
    end
  end
endmodule : tpoc_byte_reg

// File: tpoc_group.sv
// one 4-bit pattern group: trigger select, mode, next-data copy into port data
// assumes single-cycle compare-match pulses in the clk_sys domain
`timescale 1ns/1ps
`include "tpoc_defines.svh"

module tpoc_group #(
  parameter int NCH = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [1:0] chan_sel,
  input wire logic nonoverlap,
  input wire logic [NCH-1:0] match_a,
  input wire logic [NCH-1:0] match_b,
  input wire logic [3:0] next_data,
  input wire logic [3:0] xfer_en,
  input wire logic pdr_we,
  input wire logic [3:0] pdr_wdata,
  output logic [3:0] pdr
);
  import tpoc_pkg::*;

  logic trig_a;
  logic trig_b;
  logic [3:0] copy_mask;

  // two select bits cannot address any other channel count
  if (NCH != `TPOC_NCH) begin : g_bad_nch
    $error("tpoc_group: two select bits need four channels");
  end

  // ----------------------------------------
  // trigger decode
  // ----------------------------------------
  assign trig_a = match_a[chan_sel];
  assign trig_b = nonoverlap & match_b[chan_sel];

  always_comb begin
    copy_mask = 4'h0;
    if (trig_a) begin
      copy_mask = xfer_en;
    end else if (trig_b) begin
      // only zeros go out on B so falling edges lead rising ones
      copy_mask = xfer_en & ~next_data;
    end
  end

  // ----------------------------------------
  // port data
  // ----------------------------------------
  // hardware copy wins over a software write in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pdr <= `TPOC_RST_NIB;
    end else begin
      pdr <= (((pdr_we ? pdr_wdata : pdr) & ~copy_mask)
              | (next_data & copy_mask));
    end
  end
endmodule : tpoc_group

// File: tpoc_top.sv
// timing pattern output controller top: register port, four groups, pin drive
// assumes timer match/capture pulses are one clk_sys cycle, synchronous
//
// Notes on behaviour
// - upper enable bits gate next-data copy
// - trigger select resets to all ones
// - bits 7:6 pick channel for group 3
// - bits 5:4 pick channel for group 2
// - bits 3:2 pick channel for group 1
// - bits 1:0 pick channel for group 0
// - overlap mode register resets to f0
// - mode bits 7:4 read as ones
// - clear mode bit updates on match A
// - set mode bit uses matches A and B
// - pin drives data when both control bits and enable set
// - trigger copies enabled next data to port
// - disabled bits never copy
// - upper enable resets to zero
// - A copies all, B copies zeros only
`timescale 1ns/1ps
`include "tpoc_defines.svh"

module tpoc_top #(
  parameter int NCH = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire tpoc_pkg::tpoc_addr_t reg_addr,
  input wire tpoc_pkg::tpoc_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output tpoc_pkg::tpoc_byte_t reg_rdata,
  input wire logic [NCH-1:0] cmp_match_a,
  input wire logic [NCH-1:0] cmp_match_b,
  input wire logic [NCH-1:0] capture_a,
  output logic [15:0] pattern_out,
  output logic [15:0] pattern_oe
);
  import tpoc_pkg::*;

  tpoc_byte_t next_data_low;
  tpoc_byte_t next_data_high;
  tpoc_byte_t lower_transfer_enable;
  tpoc_byte_t upper_transfer_enable;
  tpoc_byte_t group_trigger_select;
  tpoc_byte_t group_overlap_mode;
  tpoc_byte_t pctl_lo;
  tpoc_byte_t pctl_hi;
  tpoc_byte_t pctl2_lo;
  tpoc_byte_t pctl2_hi;
  logic [15:0] next_data;
  logic [15:0] xfer_en;
  logic [15:0] pdr;
  logic [15:0] pdr_wdata;
  logic [15:0] ctl_one;
  logic [15:0] ctl_two;
  logic [3:0] pdr_we;
  logic [NCH-1:0] trig_a;
  tpoc_byte_t rdata_nxt;

  if (NCH != `TPOC_NCH) begin : g_bad_nch
    $error("tpoc_top: channel count must be four");
  end

  function automatic logic wr_at(input tpoc_addr_t a, input tpoc_addr_t ofs);
    wr_at = reg_wr && (a == ofs);
  endfunction : wr_at

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  tpoc_byte_reg #(.RST_VAL(`TPOC_RST_BYTE0)) u_ndl (
    .clk_sys(clk_sys), .rst(rst), .we(wr_at(reg_addr, `TPOC_OFS_NDL)),
    .wdata(reg_wdata), .q(next_data_low));
  tpoc_byte_reg #(.RST_VAL(`TPOC_RST_BYTE0)) u_ndh (
    .clk_sys(clk_sys), .rst(rst), .we(wr_at(reg_addr, `TPOC_OFS_NDH)),
    .wdata(reg_wdata), .q(next_data_high));
  tpoc_byte_reg #(.RST_VAL(`TPOC_RST_BYTE0)) u_lte (
    .clk_sys(clk_sys), .rst(rst), .we(wr_at(reg_addr, `TPOC_OFS_LTE)),
    .wdata(reg_wdata), .q(lower_transfer_enable));
  tpoc_byte_reg #(.RST_VAL(`TPOC_RST_BYTE0)) u_ute (
    .clk_sys(clk_sys), .rst(rst), .we(wr_at(reg_addr, `TPOC_OFS_UTE)),
    .wdata(reg_wdata), .q(upper_transfer_enable));
  tpoc_byte_reg #(.RST_VAL(`TPOC_RST_TSEL)) u_tsel (
    .clk_sys(clk_sys), .rst(rst), .we(wr_at(reg_addr, `TPOC_OFS_TSEL)),
    .wdata(reg_wdata), .q(group_trigger_select));
  // reserved nibble is forced so a careless write cannot clear it
  tpoc_byte_reg #(.RST_VAL(`TPOC_RST_OVM)) u_ovm (
    .clk_sys(clk_sys), .rst(rst), .we(wr_at(reg_addr, `TPOC_OFS_OVM)),
    .wdata({`TPOC_OVM_RSVD, reg_wdata[3:0]}), .q(group_overlap_mode));
  tpoc_byte_reg #(.RST_VAL(`TPOC_RST_BYTE0)) u_pc1l (
    .clk_sys(clk_sys), .rst(rst), .we(wr_at(reg_addr, `TPOC_OFS_PCTL_LO)),
    .wdata(reg_wdata), .q(pctl_lo));
  tpoc_byte_reg #(.RST_VAL(`TPOC_RST_BYTE0)) u_pc1h (
    .clk_sys(clk_sys), .rst(rst), .we(wr_at(reg_addr, `TPOC_OFS_PCTL_HI)),
    .wdata(reg_wdata), .q(pctl_hi));
  tpoc_byte_reg #(.RST_VAL(`TPOC_RST_BYTE0)) u_pc2l (
    .clk_sys(clk_sys), .rst(rst), .we(wr_at(reg_addr, `TPOC_OFS_PCTL2_LO)),
    .wdata(reg_wdata), .q(pctl2_lo));
  tpoc_byte_reg #(.RST_VAL(`TPOC_RST_BYTE0)) u_pc2h (
    .clk_sys(clk_sys), .rst(rst), .we(wr_at(reg_addr, `TPOC_OFS_PCTL2_HI)),
    .wdata(reg_wdata), .q(pctl2_hi));

  assign next_data = {next_data_high, next_data_low};
  assign xfer_en = {upper_transfer_enable, lower_transfer_enable};
  assign ctl_one = {pctl_hi, pctl_lo};
  assign ctl_two = {pctl2_hi, pctl2_lo};
  assign pdr_wdata = {reg_wdata, reg_wdata};
  assign pdr_we = {{2{wr_at(reg_addr, `TPOC_OFS_PDR_HI)}},
                   {2{wr_at(reg_addr, `TPOC_OFS_PDR_LO)}}};
  assign trig_a = cmp_match_a | capture_a;

  // ----------------------------------------
  // pattern groups
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `TPOC_NGRP; g++) begin : gen_grp
      tpoc_group #(.NCH(NCH)) u_grp (
        .clk_sys(clk_sys),
        .rst(rst),
        .chan_sel(group_trigger_select[`TPOC_SEL_W*g +: `TPOC_SEL_W]),
        .nonoverlap(group_overlap_mode[g]),
        .match_a(trig_a),
        .match_b(cmp_match_b),
        .next_data(next_data[`TPOC_GRP_W*g +: `TPOC_GRP_W]),
        .xfer_en(xfer_en[`TPOC_GRP_W*g +: `TPOC_GRP_W]),
        .pdr_we(pdr_we[g]),
        .pdr_wdata(pdr_wdata[`TPOC_GRP_W*g +: `TPOC_GRP_W]),
        .pdr(pdr[`TPOC_GRP_W*g +: `TPOC_GRP_W]));
    end
  endgenerate

  // ----------------------------------------
  // pin drive, registered so outputs lag port data by one cycle
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pattern_out <= `TPOC_RST_PINS;
      pattern_oe <= `TPOC_RST_PINS;
    end else begin
      pattern_out <= pdr;
      pattern_oe <= ctl_one & ctl_two & xfer_en;
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_comb begin
    case (reg_addr)
      `TPOC_OFS_NDL: rdata_nxt = next_data_low;
      `TPOC_OFS_NDH: rdata_nxt = next_data_high;
      `TPOC_OFS_LTE: rdata_nxt = lower_transfer_enable;
      `TPOC_OFS_UTE: rdata_nxt = upper_transfer_enable;
      `TPOC_OFS_TSEL: rdata_nxt = group_trigger_select;
      `TPOC_OFS_OVM: rdata_nxt = group_overlap_mode;
      `TPOC_OFS_PDR_LO: rdata_nxt = pdr[7:0];
      `TPOC_OFS_PDR_HI: rdata_nxt = pdr[15:8];
      `TPOC_OFS_PCTL_LO: rdata_nxt = pctl_lo;
      `TPOC_OFS_PCTL_HI: rdata_nxt = pctl_hi;
      `TPOC_OFS_PCTL2_LO: rdata_nxt = pctl2_lo;
      `TPOC_OFS_PCTL2_HI: rdata_nxt = pctl2_hi;
      default: rdata_nxt = `TPOC_RD_NONE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= `TPOC_RD_NONE;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= `TPOC_RD_NONE;
    end
  end
endmodule : tpoc_top

// File: tpoc_top_props.sv
// checker for the pattern controller top ports
// assumes bind onto tpoc_top, one clock, sync reset
`timescale 1ns/1ps
module tpoc_top_props
  import tpoc_pkg::*;
#(
  parameter int NCH = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire tpoc_pkg::tpoc_addr_t reg_addr,
  input wire tpoc_pkg::tpoc_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire tpoc_pkg::tpoc_byte_t reg_rdata,
  input wire logic [NCH-1:0] cmp_match_a,
  input wire logic [NCH-1:0] cmp_match_b,
  input wire logic [NCH-1:0] capture_a,
  input wire logic [15:0] pattern_out,
  input wire logic [15:0] pattern_oe
);
  logic fresh_r;
  logic quiet;
  // no event and no write: nothing may move the pins
  assign quiet = !reg_wr && !(|cmp_match_a) && !(|cmp_match_b) && !(|capture_a);
  always_ff @(posedge clk_sys) begin
    if (rst) fresh_r <= 1'b1;
    else if (reg_wr) fresh_r <= 1'b0;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_tsel_reset_ff: assert property (fresh_r && reg_rd && reg_addr == 4'h4 |=> reg_rdata == 8'hff)
    else $error("trigger select reset");
  a_mode_reset_f0: assert property (fresh_r && reg_rd && reg_addr == 4'h5 |=> reg_rdata == 8'hf0)
    else $error("overlap mode reset");
  a_upper_en_zero: assert property (fresh_r && reg_rd && reg_addr == 4'h3 |=> reg_rdata == 8'h00)
    else $error("upper enable reset");
  a_mode_rsvd_ones: assert property (reg_rd && reg_addr == 4'h5 |=> reg_rdata[7:4] == 4'hf)
    else $error("reserved mode bits");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 4'hb |=> reg_rdata == 8'h00)
    else $error("unmapped read");
  a_quiet_hold: assert property (quiet ##1 quiet |=> $stable(pattern_out))
    else $error("pins moved without event");
  a_oe_hold: assert property (!reg_wr [*2] |=> $stable(pattern_oe))
    else $error("drive enable moved");
endmodule : tpoc_top_props

bind tpoc_top tpoc_top_props #(.NCH(NCH)) u_props (.clk_sys(clk_sys), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .cmp_match_a(cmp_match_a), .cmp_match_b(cmp_match_b),
  .capture_a(capture_a), .pattern_out(pattern_out), .pattern_oe(pattern_oe));

// File: tpoc_timer_model.sv
// timer unit stand-in: one-cycle match and capture pulses on request
// assumes requests only while idle, all on clk_sys
`timescale 1ns/1ps
module tpoc_timer_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic go,
  input wire logic [1:0] ch,
  input wire logic nov,
  input wire logic cap,
  input wire logic [3:0] gap,
  output logic [3:0] cmp_match_a,
  output logic [3:0] cmp_match_b,
  output logic [3:0] capture_a,
  output logic busy
);
  logic [4:0] cnt_r;
  logic [4:0] b_at_r;
  logic [1:0] ch_r;
  logic nov_r;
  logic cap_r;
  assign busy = (cnt_r != 5'h00);
  always_ff @(posedge clk_sys) begin
    cmp_match_a <= '0;
    cmp_match_b <= '0;
    capture_a <= '0;
    if (rst) begin
      cnt_r <= '0;
    end else if (go) begin
      // gap 8 lands B on top of A, so both match in one cycle
      cnt_r <= nov ? ((gap == 4'h8) ? 5'h01 : {1'b0, gap} + 5'h02) : 5'h01;
      b_at_r <= (gap == 4'h8) ? 5'h01 : {1'b0, gap} + 5'h02;
      ch_r <= ch;
      nov_r <= nov;
      cap_r <= cap;
    end else if (busy) begin
      cnt_r <= cnt_r - 5'h01;
      // cycle end on B first, gap later on A
      if (nov_r && cnt_r == b_at_r) cmp_match_b <= 4'h1 << ch_r;
      if (cnt_r == 5'h01 && cap_r) capture_a <= 4'h1 << ch_r;
      else if (cnt_r == 5'h01) cmp_match_a <= 4'h1 << ch_r;
    end
  end
endmodule : tpoc_timer_model

// File: tb_timing_pattern_output_ctrl.sv
// self-checking bench: register port, timer stand-in, shadow copy model
// assumes the timer stand-in and the bound checker are compiled alongside
`timescale 1ns/1ps
module tb_timing_pattern_output_ctrl;
  import tpoc_pkg::*;
  logic clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, go = 0, nov = 0, cap = 0, busy;
  tpoc_addr_t reg_addr = '0;
  tpoc_byte_t reg_wdata = '0, reg_rdata, tsel = 8'hff, ovm = 8'hf0;
  logic [1:0] ch = '0;
  logic [3:0] gap = '0, cma, cmb, capa;
  logic [15:0] pattern_out, pattern_oe, nd = '0, te = '0, exp_pdr = '0, exp_d = '0;
  logic [15:0] pc1 = '0, pc2 = '0;
  int num_errors = 0, check_count = 0;
  always #5 clk_sys = ~clk_sys;
  tpoc_top #(.NCH(4)) DUT (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmp_match_a(cma), .cmp_match_b(cmb), .capture_a(capa), .pattern_out(pattern_out),
    .pattern_oe(pattern_oe));
  tpoc_timer_model u_tmr (.clk_sys(clk_sys), .rst(rst), .go(go), .ch(ch), .nov(nov),
    .cap(cap), .gap(gap), .cmp_match_a(cma), .cmp_match_b(cmb), .capture_a(capa), .busy(busy));
  function automatic logic [15:0] upd(logic [15:0] p, logic [3:0] a, logic [3:0] b);
    logic [3:0] m;
    logic [3:0] n;
    for (int g = 0; g < 4; g++) begin
      m = te[4*g+:4];
      n = nd[4*g+:4];
      if (a[tsel[2*g+:2]]) p[4*g+:4] = (p[4*g+:4] & ~m) | (n & m);
      else if (b[tsel[2*g+:2]] && ovm[g]) p[4*g+:4] = p[4*g+:4] & ~(m & ~n);
    end
    return p;
  endfunction : upd
  // software port data write lands first, a copy in the same edge overrides it
  function automatic logic [15:0] swr(logic [15:0] p);
    if (reg_wr && reg_addr == 4'h6) p[7:0] = reg_wdata;
    if (reg_wr && reg_addr == 4'h7) p[15:8] = reg_wdata;
    return p;
  endfunction : swr
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    check_count++;
    if (s !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, s);
      num_errors++;
    end
  endtask : chk
  task automatic close_out();
    if (num_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
  endtask : rd
  task automatic fire();
    int i;
    @(posedge clk_sys);
    go <= 1'b1;
    ch <= 2'($urandom);
    nov <= 1'($urandom);
    cap <= 1'($urandom);
    gap <= 4'($urandom_range(0, 8));
    @(posedge clk_sys);
    go <= 1'b0;
    #1;
    for (i = 0; i < 40 && busy; i++) begin
      @(posedge clk_sys);
      #1;
    end
    if (i == 40) begin
      num_errors++;
      close_out();
    end
    repeat (3) @(posedge clk_sys);
  endtask : fire
  // pins follow port data one edge later
  always @(posedge clk_sys) begin
    if (rst) begin
      exp_pdr <= '0;
      exp_d <= '0;
    end else begin
      chk("pattern_out", exp_d, pattern_out);
      exp_d <= exp_pdr;
      exp_pdr <= upd(swr(exp_pdr), cma | capa, cmb);
    end
  end
  initial begin
    void'($urandom(32'h88fc_fc56));
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    rd(4'h4, 8'hff);
    rd(4'h5, 8'hf0);
    rd(4'h3, 8'h00);
    rd(4'hc, 8'h00);
    wr(4'h5, 8'h00);
    rd(4'h5, 8'hf0);
    for (int r = 8; r < 12; r++) wr(4'(r), 8'hff);
    for (int k = 0; k < 60; k++) begin
      nd = 16'($urandom);
      te = (k == 0) ? 16'hffff : (k == 1) ? 16'h0000 : 16'($urandom);
      tsel = 8'($urandom);
      ovm = {4'hf, 4'($urandom)};
      pc1 = (k < 4) ? 16'hffff : 16'($urandom);
      pc2 = (k < 4) ? 16'hffff : 16'($urandom);
      wr(4'h8, pc1[7:0]);
      wr(4'h9, pc1[15:8]);
      wr(4'ha, pc2[7:0]);
      wr(4'hb, pc2[15:8]);
      wr(4'h6, 8'($urandom));
      wr(4'h7, 8'($urandom));
      wr(4'h0, nd[7:0]);
      wr(4'h1, nd[15:8]);
      wr(4'h2, te[7:0]);
      wr(4'h3, te[15:8]);
      wr(4'h4, tsel);
      wr(4'h5, ovm);
      chk("pattern_oe", te & pc1 & pc2, pattern_oe);
      fire();
      rd(4'h6, exp_pdr[7:0]);
      rd(4'h7, exp_pdr[15:8]);
      rd(4'h4, tsel);
      rd(4'h5, ovm);
    end
    close_out();
  end
endmodule : tb_timing_pattern_output_ctrl
